// ### hdl/pcm_mode_config.sv
// mode and pwm configuration registers of the counter array
`timescale 1ns/1ps
`default_nettype none
module pcm_mode_config #(
    parameter int NUM_MODULES = pcm_pkg::NUM_MODULES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrRead,
    output logic [7:0] sfrRdata,
    output logic sfrHit,
    input wire logic [NUM_MODULES-1:0] compareLowWrite,
    input wire logic [15:0] arrayCounter,
    input wire logic [NUM_MODULES-1:0] compareMatch,
    input wire logic [NUM_MODULES-1:0] moduleEventFlag,
    input wire logic [NUM_MODULES-1:0] captureInputPin,
    input wire logic watchdogEnableBit,
    output logic reloadBankSelect,
    output logic [1:0] cycleLengthSel,
    output logic [NUM_MODULES-1:0] useReloadBank,
    output logic [NUM_MODULES-1:0] pwmWide,
    output logic [NUM_MODULES-1:0] compareActive,
    output logic [NUM_MODULES-1:0] riseCaptureEvent,
    output logic [NUM_MODULES-1:0] fallCaptureEvent,
    output logic [NUM_MODULES-1:0] matchFlagSet,
    output logic [NUM_MODULES-1:0] toggleOnMatch,
    output logic [NUM_MODULES-1:0] pwmOutputActive,
    output logic [NUM_MODULES-1:0] freqOutputMode,
    output logic [NUM_MODULES-1:0] moduleOutputPin,
    output logic [NUM_MODULES*3-1:0] moduleModeCode,
    output logic cycleWrapFlag,
    output logic arrayIrq
);
    typedef struct packed {
        logic [7:0] pwmCfg;
        logic [NUM_MODULES-1:0][7:0] mode;
        logic [NUM_MODULES-1:0] pinLevel;
        logic [NUM_MODULES-1:0] pinSync1;
        logic [NUM_MODULES-1:0] pinSync2;
        logic [NUM_MODULES-1:0] pinPrev;
        logic [7:0] rdata;
    } pcm_cfg_state_t;

    pcm_cfg_state_t state_reg;
    pcm_cfg_state_t state_next;
    logic wrapPulse;
    logic cfgHit;
    logic [NUM_MODULES-1:0] modeHit;
    logic [NUM_MODULES-1:0] capReady;
    logic [NUM_MODULES-1:0] liveMatch;

    pcm_wrap_detect u_wrap (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .counterValue(arrayCounter),
        .cycleLengthSel(cycleLengthSel),
        .wrapPulse(wrapPulse)
    );

    assign cfgHit = (sfrAddr == pcm_pkg::ADDR_PWM_CFG);
    assign sfrHit = cfgHit || (|modeHit);
    assign sfrRdata = state_reg.rdata;
    assign reloadBankSelect = state_reg.pwmCfg[pcm_pkg::BIT_RELOAD_SEL];
    assign cycleLengthSel = state_reg.pwmCfg[pcm_pkg::BIT_CLSEL_HI:pcm_pkg::BIT_CLSEL_LO];
    assign cycleWrapFlag = state_reg.pwmCfg[pcm_pkg::BIT_WRAP_FLAG];

    // module event flags live elsewhere; masking happens here
    always_comb begin
        arrayIrq = state_reg.pwmCfg[pcm_pkg::BIT_WRAP_IRQ_EN] && cycleWrapFlag;
        for (int k = 0; k < NUM_MODULES; k++) begin
            if (state_reg.mode[k][pcm_pkg::BIT_EVT_IRQ] && moduleEventFlag[k]) begin
                arrayIrq = 1'b1;
            end
        end
    end

    genvar m;
    generate
        for (m = 0; m < NUM_MODULES; m++) begin : g_mod
            logic [7:0] md;
            logic pwmOn;
            logic togOn;
            logic [2:0] code;
            assign md = state_reg.mode[m];
            assign modeHit[m] = (sfrAddr == pcm_pkg::ADDR_MODE0 + 8'(m));
            assign pwmOn = md[pcm_pkg::BIT_PWM];
            assign togOn = md[pcm_pkg::BIT_TOGGLE];
            assign pwmWide[m] = pwmOn && md[pcm_pkg::BIT_WIDE_PWM];
            // narrow pwm alone consumes the reload registers
            assign useReloadBank[m] = pwmOn && !md[pcm_pkg::BIT_WIDE_PWM] && !togOn;
            assign compareActive[m] = md[pcm_pkg::BIT_COMPARE];
            // comparator off: raw equality pulses must not reach flag or pin
            assign liveMatch[m] = compareMatch[m] && md[pcm_pkg::BIT_COMPARE];
            assign capReady[m] = state_reg.pinPrev[m] != state_reg.pinSync2[m];
            assign riseCaptureEvent[m] = clkEn && capReady[m] && state_reg.pinSync2[m]
                && md[pcm_pkg::BIT_RISE_CAP];
            assign fallCaptureEvent[m] = clkEn && capReady[m] && !state_reg.pinSync2[m]
                && md[pcm_pkg::BIT_FALL_CAP];
            assign matchFlagSet[m] = clkEn && liveMatch[m]
                && md[pcm_pkg::BIT_MATCH];
            assign freqOutputMode[m] = togOn && pwmOn;
            assign toggleOnMatch[m] = togOn && !pwmOn;
            assign pwmOutputActive[m] = pwmOn && !togOn;
            assign moduleOutputPin[m] = state_reg.pinLevel[m];
            // local code keeps each slice of the packed output to one driver
            always_comb begin
                if (freqOutputMode[m]) begin
                    code = pcm_pkg::PCM_FREQ_OUT;
                end else if (pwmWide[m]) begin
                    code = pcm_pkg::PCM_PWM_WIDE;
                end else if (pwmOn) begin
                    code = pcm_pkg::PCM_PWM_NARROW;
                end else if (togOn) begin
                    code = pcm_pkg::PCM_TOGGLE;
                end else if (md[pcm_pkg::BIT_MATCH]) begin
                    code = pcm_pkg::PCM_SOFT_TIMER;
                end else if (md[pcm_pkg::BIT_RISE_CAP] || md[pcm_pkg::BIT_FALL_CAP]) begin
                    code = pcm_pkg::PCM_CAPTURE;
                end else begin
                    code = pcm_pkg::PCM_OFF;
                end
            end
            assign moduleModeCode[m*3 +: 3] = code;
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        state_next.pinSync1 = captureInputPin;
        state_next.pinSync2 = state_reg.pinSync1;
        state_next.pinPrev = state_reg.pinSync2;
        // register writes
        if (sfrWrite && cfgHit) begin
            state_next.pwmCfg = sfrWdata & pcm_pkg::PWM_CFG_WRITE_MASK;
        end
        // hardware set wins over a software clear in the same cycle
        if (wrapPulse) begin
            state_next.pwmCfg[pcm_pkg::BIT_WRAP_FLAG] = 1'b1;
        end
        for (int k = 0; k < NUM_MODULES; k++) begin
            if (sfrWrite && modeHit[k]
                && !(k == pcm_pkg::WATCHDOG_MODULE && watchdogEnableBit)) begin
                state_next.mode[k] = sfrWdata;
            end
            if (compareLowWrite[k]) begin
                state_next.mode[k][pcm_pkg::BIT_COMPARE] = 1'b0;
            end
            // pin follows match in toggle and frequency modes
            if (liveMatch[k] && state_reg.mode[k][pcm_pkg::BIT_TOGGLE]) begin
                state_next.pinLevel[k] = !state_reg.pinLevel[k];
            end else if (pwmOutputActive[k]) begin
                // pin low until match, high from match to cycle end
                if (liveMatch[k]) begin
                    state_next.pinLevel[k] = 1'b1;
                end else if (wrapPulse && !pwmWide[k]) begin
                    state_next.pinLevel[k] = 1'b0;
                end else if (pwmWide[k] && arrayCounter == 16'hffff) begin
                    state_next.pinLevel[k] = 1'b0;
                end
            end
        end
        // read data captured from current register contents
        state_next.rdata = 8'h00;
        if (sfrRead && cfgHit) begin
            state_next.rdata = state_reg.pwmCfg & pcm_pkg::PWM_CFG_WRITE_MASK;
        end
        for (int k = 0; k < NUM_MODULES; k++) begin
            if (sfrRead && modeHit[k]) begin
                state_next.rdata = state_reg.mode[k];
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end
endmodule
`default_nettype wire

// ### hdl/pcm_pkg.sv
// constants for the counter-array mode and pwm configuration block
package pcm_pkg;
    localparam int NUM_MODULES = 6;
    localparam logic [7:0] ADDR_PWM_CFG = 8'hd9;
    localparam logic [7:0] ADDR_MODE0 = 8'hda;
    localparam logic [7:0] ADDR_MODE1 = 8'hdb;
    localparam logic [7:0] ADDR_MODE2 = 8'hdc;
    localparam logic [7:0] ADDR_MODE3 = 8'hdd;
    localparam logic [7:0] ADDR_MODE4 = 8'hde;
    localparam logic [7:0] ADDR_MODE5 = 8'hdf;
    localparam logic [7:0] RESET_PWM_CFG = 8'h00;
    localparam logic [7:0] RESET_MODE = 8'h00;
    localparam logic [7:0] PWM_CFG_WRITE_MASK = 8'he3;
    // pwm config fields
    localparam int BIT_RELOAD_SEL = 7;
    localparam int BIT_WRAP_IRQ_EN = 6;
    localparam int BIT_WRAP_FLAG = 5;
    localparam int BIT_CLSEL_HI = 1;
    localparam int BIT_CLSEL_LO = 0;
    // mode register fields
    localparam int BIT_WIDE_PWM = 7;
    localparam int BIT_COMPARE = 6;
    localparam int BIT_RISE_CAP = 5;
    localparam int BIT_FALL_CAP = 4;
    localparam int BIT_MATCH = 3;
    localparam int BIT_TOGGLE = 2;
    localparam int BIT_PWM = 1;
    localparam int BIT_EVT_IRQ = 0;
    localparam int WATCHDOG_MODULE = 5;
    localparam logic [1:0] CLSEL_8 = 2'h0;
    localparam logic [1:0] CLSEL_9 = 2'h1;
    localparam logic [1:0] CLSEL_10 = 2'h2;
    localparam logic [1:0] CLSEL_11 = 2'h3;
    typedef enum logic [2:0] {
        PCM_OFF = 3'b000,
        PCM_CAPTURE = 3'b001,
        PCM_SOFT_TIMER = 3'b010,
        PCM_TOGGLE = 3'b011,
        PCM_PWM_NARROW = 3'b100,
        PCM_PWM_WIDE = 3'b101,
        PCM_FREQ_OUT = 3'b110
    } pcm_mode_t;
endpackage

// ### hdl/pcm_wrap_detect.sv
// detects the selected cycle-length wrap of the array counter
`timescale 1ns/1ps
`default_nettype none
module pcm_wrap_detect (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic [15:0] counterValue,
    input wire logic [1:0] cycleLengthSel,
    output logic wrapPulse
);
    typedef struct packed {
        logic [15:0] prevCount;
        logic primed;
    } pcm_wrap_state_t;

    pcm_wrap_state_t state_reg;
    pcm_wrap_state_t state_next;
    logic [3:0] topBit;

    always_comb begin
        case (cycleLengthSel)
            pcm_pkg::CLSEL_8: topBit = 4'h7;
            pcm_pkg::CLSEL_9: topBit = 4'h8;
            pcm_pkg::CLSEL_10: topBit = 4'h9;
            default: topBit = 4'ha;
        endcase
    end

    // a wrap is the chosen bit falling from one to zero
    assign wrapPulse = state_reg.primed && clkEn && state_reg.prevCount[topBit]
        && !counterValue[topBit];

    always_comb begin
        state_next = state_reg;
        state_next.prevCount = counterValue;
        state_next.primed = 1'b1;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end
endmodule
`default_nettype wire

// ### sim/pcm_pin_model.sv
// far-side model: external levels on the module capture pins
`timescale 1ns/1ps
`default_nettype none
module pcm_pin_model (
    input wire logic core_clk,
    input wire logic [5:0] pinCmd,
    output logic [5:0] captureInputPin
);
    initial captureInputPin = 6'h00;
    // pins move off the clock edge, as a real outside source would
    always @(posedge core_clk) captureInputPin <= #3 pinCmd;
endmodule
`default_nettype wire

// ### sim/pcm_mode_config_properties.sv
// assertions on the ports of the mode and pwm configuration block
`timescale 1ns/1ps
`default_nettype none
module pcm_mode_config_properties #(
    parameter int NUM_MODULES = 6
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrRdata,
    input wire logic [NUM_MODULES-1:0] compareLowWrite,
    input wire logic [15:0] arrayCounter,
    input wire logic [NUM_MODULES-1:0] compareMatch,
    input wire logic [NUM_MODULES-1:0] moduleEventFlag,
    input wire logic watchdogEnableBit,
    input wire logic [1:0] cycleLengthSel,
    input wire logic [NUM_MODULES-1:0] useReloadBank,
    input wire logic [NUM_MODULES-1:0] pwmWide,
    input wire logic [NUM_MODULES-1:0] compareActive,
    input wire logic [NUM_MODULES-1:0] matchFlagSet,
    input wire logic [NUM_MODULES-1:0] toggleOnMatch,
    input wire logic [NUM_MODULES-1:0] freqOutputMode,
    input wire logic [NUM_MODULES-1:0] moduleOutputPin,
    input wire logic cycleWrapFlag,
    input wire logic arrayIrq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    localparam logic [7:0] CFG = pcm_pkg::ADDR_PWM_CFG;
    AST_RD_ZERO: assert property (clkEn && sfrRead && sfrAddr == CFG
        |=> sfrRdata[4:2] == 3'h0) else $error("config reserved bits read nonzero");
    AST_WRAP_SET: assert property (clkEn && $past(clkEn) && $past(reset_n)
        && $stable(cycleLengthSel)
        && $fell(arrayCounter[cycleLengthSel + 4'h7]) |=> cycleWrapFlag)
        else $error("wrap flag not set on counter wrap");
    AST_WRAP_HOLD: assert property (cycleWrapFlag && !(sfrWrite && sfrAddr == CFG)
        |=> cycleWrapFlag) else $error("wrap flag cleared without software");
    AST_IRQ_SRC: assert property (arrayIrq |-> cycleWrapFlag || moduleEventFlag != 6'h00)
        else $error("array irq without a flag");
    AST_LOW_CLR: assert property (clkEn && compareLowWrite != 6'h00
        |=> (compareActive & $past(compareLowWrite)) == 6'h00) else $error("compare stays on");
    AST_WD_LOCK: assert property (watchdogEnableBit && clkEn && sfrWrite
        && sfrAddr == pcm_pkg::ADDR_MODE5 |=> !$rose(compareActive[5])) else $error("mode5 written");
    AST_MATCH: assert property ((matchFlagSet & ~(compareMatch & compareActive)) == 6'h00)
        else $error("match flag without match");
    AST_FREQ: assert property ((freqOutputMode & toggleOnMatch) == 6'h00)
        else $error("freq mode also plain toggle");
    AST_WIDE: assert property ((useReloadBank & pwmWide) == 6'h00)
        else $error("wide pwm uses reload bank");
    AST_TOG: assert property (clkEn && toggleOnMatch[0] && compareMatch[0] && compareActive[0]
        |=> moduleOutputPin[0] != $past(moduleOutputPin[0])) else $error("pin did not toggle");
    cover property (cycleWrapFlag && arrayIrq);
    cover property (toggleOnMatch[0] && compareMatch[0]);
    cover property (compareLowWrite[0] && compareActive[0]);
    cover property (matchFlagSet[0]);
endmodule
bind pcm_mode_config pcm_mode_config_properties #(.NUM_MODULES(NUM_MODULES)) chk_i (.*);
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the mode and pwm configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk = 1'b0, reset_n = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0;
    logic watchdogEnableBit = 1'b0, reloadBankSelect, cycleWrapFlag, arrayIrq, p;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
    logic [5:0] compareLowWrite = 6'h00, compareMatch = 6'h00, pinCmd = 6'h00;
    logic [5:0] captureInputPin, compareActive, riseCaptureEvent, fallCaptureEvent;
    logic [5:0] toggleOnMatch, moduleOutputPin, useReloadBank, pwmWide, matchFlagSet;
    logic [5:0] pwmOutputActive, freqOutputMode, moduleEventFlag = 6'h00;
    logic clkEn = 1'b1, sfrHit;
    logic [4:0] outKind;
    logic [15:0] arrayCounter = 16'h0000;
    logic [17:0] moduleModeCode;
    logic [1:0] cycleLengthSel;
    logic [7:0] mv [7] = '{8'h00, 8'h20, 8'h48, 8'h4c, 8'h42, 8'hc2, 8'h46};
    // expected {freq, pwm, toggle, reload, wide} of module 0 for each mode above
    logic [4:0] ov [7] = '{5'h00, 5'h00, 5'h00, 5'h04, 5'h0a, 5'h09, 5'h10};
    int n_fail = 0, cmp_count = 0, cyc = 0, got;
    pcm_mode_config pcm_mode_config_i (.*);
    assign outKind = {freqOutputMode[0], pwmOutputActive[0], toggleOnMatch[0], useReloadBank[0],
        pwmWide[0]};
    pcm_pin_model pcm_pin_model_i (.core_clk(core_clk), .pinCmd(pinCmd),
        .captureInputPin(captureInputPin));
    always #5 core_clk = ~core_clk;
    task end_sim;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            end_sim;
        end
    end
    task chk(input logic [17:0] seen, input logic [17:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfrAddr <= a;
        sfrWdata <= d;
        sfrWrite <= 1'b1;
        @(posedge core_clk);
        sfrWrite <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        sfrAddr <= a;
        sfrRead <= 1'b1;
        @(posedge core_clk);
        sfrRead <= 1'b0;
        #1 chk(sfrRdata, e);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(8'hd9 + i[7:0], 8'h00);
            chk(sfrHit, 1'b1);
        end
        rd(8'he0, 8'h00);
        chk(sfrHit, 1'b0);
        wr(8'hd9, 8'hff);
        rd(8'hd9, 8'he3);
        chk({reloadBankSelect, cycleLengthSel}, 18'h7);
        wr(8'hd9, 8'h00);
        chk(cycleWrapFlag, 1'b0);
        $display("config test done");
        // odd selects also enable the wrap interrupt, so masking is seen both ways
        for (int s = 0; s < 4; s++) begin
            wr(8'hd9, {1'b0, s[0], 4'h0, s[1:0]});
            @(posedge core_clk) arrayCounter <= 16'h0001 << (7 + s);
            @(posedge core_clk) arrayCounter <= 16'h0000;
            repeat (2) @(posedge core_clk);
            #1 chk({cycleWrapFlag, arrayIrq}, {1'b1, s[0]});
        end
        // wrap and software clear land on the same edge: the set must win
        wr(8'hd9, 8'h00);
        @(posedge core_clk) arrayCounter <= 16'h0080;
        fork
            wr(8'hd9, 8'h00);
            @(posedge core_clk) arrayCounter <= 16'h0000;
        join
        chk(cycleWrapFlag, 1'b1);
        wr(8'hd9, 8'h00);
        chk(cycleWrapFlag, 1'b0);
        wr(8'hd9, 8'h20);
        chk(cycleWrapFlag, 1'b1);
        $display("wrap test done");
        for (int k = 0; k < 7; k++) begin
            wr(8'hda, mv[k]);
            rd(8'hda, mv[k]);
            chk(moduleModeCode[2:0], k[2:0]);
            chk(outKind, ov[k]);
        end
        wr(8'hda, 8'h04);
        p = moduleOutputPin[0];
        @(posedge core_clk) compareMatch <= 6'h01;
        @(posedge core_clk) compareMatch <= 6'h00;
        #1 chk(moduleOutputPin[0], p);
        wr(8'hda, 8'h4c);
        @(posedge core_clk) compareMatch <= 6'h01;
        #1 chk(matchFlagSet, 6'h01);
        @(posedge core_clk) compareMatch <= 6'h00;
        #1 chk(moduleOutputPin[0], !p);
        chk(compareActive[0], 1'b1);
        @(posedge core_clk) compareLowWrite <= 6'h01;
        @(posedge core_clk) compareLowWrite <= 6'h00;
        #1 chk(compareActive[0], 1'b0);
        wr(8'hda, 8'h42);
        @(posedge core_clk) arrayCounter <= 16'h0080;
        @(posedge core_clk) arrayCounter <= 16'h0000;
        repeat (2) @(posedge core_clk);
        #1 chk(moduleOutputPin[0], 1'b0);
        @(posedge core_clk) compareMatch <= 6'h01;
        @(posedge core_clk) compareMatch <= 6'h00;
        #1 chk(moduleOutputPin[0], 1'b1);
        wr(8'hda, 8'hc2);
        @(posedge core_clk) arrayCounter <= 16'h0080;
        @(posedge core_clk) arrayCounter <= 16'h0000;
        repeat (2) @(posedge core_clk);
        #1 chk(moduleOutputPin[0], 1'b1);
        @(posedge core_clk) arrayCounter <= 16'hffff;
        @(posedge core_clk) arrayCounter <= 16'h0000;
        #1 chk(moduleOutputPin[0], 1'b0);
        @(posedge core_clk) watchdogEnableBit <= 1'b1;
        wr(8'hdf, 8'hff);
        rd(8'hdf, 8'h00);
        @(posedge core_clk) watchdogEnableBit <= 1'b0;
        wr(8'hdf, 8'h60);
        rd(8'hdf, 8'h60);
        $display("mode test done");
        for (int e = 0; e < 2; e++) begin
            wr(8'hdb, e ? 8'h10 : 8'h20);
            @(posedge core_clk) pinCmd <= e ? 6'h00 : 6'h02;
            got = 0;
            repeat (8) @(posedge core_clk) #1 got += e ? fallCaptureEvent[1] : riseCaptureEvent[1];
            chk(got[17:0], 18'h1);
        end
        $display("capture test done");
        @(posedge core_clk) moduleEventFlag <= 6'h04;
        #1 chk(arrayIrq, 1'b0);
        wr(8'hdc, 8'h01);
        chk(arrayIrq, 1'b1);
        // a write while the enable is low must leave every register frozen
        @(posedge core_clk) clkEn <= 1'b0;
        wr(8'hd9, 8'h80);
        @(posedge core_clk) clkEn <= 1'b1;
        #1 chk(reloadBankSelect, 1'b0);
        @(posedge core_clk) reset_n <= 1'b0;
        #1 chk({arrayIrq, cycleWrapFlag}, 2'h0);
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(8'hdc, 8'h00);
        $display("irq freeze reset test done");
        end_sim;
    end
endmodule
`default_nettype wire
